// >>> shared/rtfc_pkg.sv
// Constants, types and state encodings for the radio transmit fault control block
// Assumes one 100 MHz clock and inputs synchronous to it
// Contract
// - Fault lamp lights when any receiver lock monitor reports unlock (one high, two low).
// - Fault lamp lights when transmitter lock monitor input is high.
// - Fault lamp lights when receiver and transmitter band flags differ.
// - Fault lamp lights on low transmit power, checked only while keyed.
// - Any fault blocks receive audio and sidetone from the line output.
// - Keying from the selected source, local or remote, puts the relay in transmit position.
// - Amplifiers may turn on only while keyed and transmitter locked.
// - Permitted with band flag low: upper amplifier on, lower amplifier off.
// - Permitted with band flag high: lower amplifier on, upper amplifier off.
// - While keyed, receive audio is cut from amplifiers and loudspeaker inhibited.
// - Local/remote select picks keying and audio source.
// - Panel selecting amplitude mode lights that lamp, frequency lamp off.
// - Frequency lamp and mode only when selected and upper band.
// - Amplitude mode or lower band routes audio to driver, otherwise to synthesiser.
// - Modulation depth setting follows transmitter band flag.
// - Transmitting sends sidetone to headphones, and line output without fault.
// - Receiving passes receive audio to speaker, headphones, line without fault.
package rtfc_pkg;

	localparam int SYNC_STAGES = 2;
	localparam int NUM_INPUTS = 11;
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;
	localparam logic [NUM_INPUTS-1:0] INPUT_RESET = 11'h000;

	// Input bit positions in the synchronised vector
	localparam int IX_RX_OSC1_UNLOCK = 0;
	localparam int IX_SECOND_OSC_LOCK = 1;
	localparam int IX_RX_OSC3_LOCK = 2;
	localparam int IX_TX_UNLOCK = 3;
	localparam int IX_RX_BAND = 4;
	localparam int IX_TX_BAND = 5;
	localparam int IX_POWER_OK = 6;
	localparam int IX_LOCAL_KEY = 7;
	localparam int IX_REMOTE_KEY = 8;
	localparam int IX_REMOTE_SEL = 9;
	localparam int IX_AM_SEL = 10;

	typedef enum logic [1:0] {
		RTFC_ST_SETTLE = 2'h1,
		RTFC_ST_RUN = 2'h2
	} rtfc_state_t;

	typedef struct packed {
		logic upper_pa_on;
		logic lower_pa_on;
		logic relay_tx;
	} rtfc_tx_ctrl_t;

	typedef struct packed {
		logic rx_to_amps;
		logic speaker_on;
		logic headphone_rx;
		logic headphone_sidetone;
		logic line_rx;
		logic line_sidetone;
		logic remote_audio_src;
		logic am_driver_route;
		logic depth_lower_band;
	} rtfc_audio_ctrl_t;

	typedef struct packed {
		logic fault_lamp;
		logic am_lamp;
		logic fm_lamp;
	} rtfc_lamps_t;

endpackage

// >>> src/rtfc_top.sv
// Fault gathering, keying, amplifier and lamp control of the audio and control unit
// Assumes level inputs synchronous to clk; analogue paths are steered by the outputs
`timescale 1ns/1ps
module rtfc_top #(
	parameter int NUM_IN = rtfc_pkg::NUM_INPUTS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic rx_osc1_unlock,
	input wire logic second_osc_unlock_n,
	input wire logic rx_osc3_unlock_n,
	input wire logic tx_unlock,
	input wire logic rx_band_flag,
	input wire logic tx_band_flag,
	input wire logic tx_power_ok,
	input wire logic local_key,
	input wire logic remote_key,
	input wire logic remote_select,
	input wire logic am_select,
	output rtfc_pkg::rtfc_tx_ctrl_t tx_ctrl,
	output rtfc_pkg::rtfc_audio_ctrl_t audio_ctrl,
	output rtfc_pkg::rtfc_lamps_t lamps,
	output logic inputs_valid
);

	logic [NUM_IN-1:0] raw_in;
	logic [NUM_IN-1:0] sync_meta;
	logic [NUM_IN-1:0] sync_in;
	logic [1:0] settle_count;
	logic [1:0] next_settle_count;
	rtfc_pkg::rtfc_state_t state;
	rtfc_pkg::rtfc_state_t next_state;
	rtfc_pkg::rtfc_tx_ctrl_t next_tx_ctrl;
	rtfc_pkg::rtfc_audio_ctrl_t next_audio_ctrl;
	rtfc_pkg::rtfc_lamps_t next_lamps;

	assign raw_in = {am_select, remote_select, remote_key, local_key, tx_power_ok,
		tx_band_flag, rx_band_flag, tx_unlock, rx_osc3_unlock_n, second_osc_unlock_n,
		rx_osc1_unlock};

	// First stage is read only by the second stage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_meta <= rtfc_pkg::INPUT_RESET;
			sync_in <= rtfc_pkg::INPUT_RESET;
		end else begin
			sync_meta <= raw_in;
			sync_in <= sync_meta;
		end
	end

	wire s_osc1_unlock = sync_in[rtfc_pkg::IX_RX_OSC1_UNLOCK];
	wire s_osc2_lock = sync_in[rtfc_pkg::IX_SECOND_OSC_LOCK];
	wire s_osc3_lock = sync_in[rtfc_pkg::IX_RX_OSC3_LOCK];
	wire s_tx_unlock = sync_in[rtfc_pkg::IX_TX_UNLOCK];
	wire s_rx_band = sync_in[rtfc_pkg::IX_RX_BAND];
	wire s_tx_band = sync_in[rtfc_pkg::IX_TX_BAND];
	wire s_power_ok = sync_in[rtfc_pkg::IX_POWER_OK];
	wire s_remote_sel = sync_in[rtfc_pkg::IX_REMOTE_SEL];
	wire s_am_sel = sync_in[rtfc_pkg::IX_AM_SEL];

	// Source select picks one key; the other is ignored
	wire key_src = s_remote_sel ? sync_in[rtfc_pkg::IX_REMOTE_KEY]
		: sync_in[rtfc_pkg::IX_LOCAL_KEY];
	wire run = (state == rtfc_pkg::RTFC_ST_RUN);
	wire keyed = key_src & run;

	// Second oscillator monitor arrives active low from its sub-module
	wire rx_unlock = s_osc1_unlock | ~s_osc2_lock | ~s_osc3_lock;
	wire band_mismatch = s_rx_band ^ s_tx_band;
	wire low_power = keyed & ~s_power_ok;
	wire fault = rx_unlock | s_tx_unlock | band_mismatch | low_power;

	wire tx_permit = keyed & ~s_tx_unlock;
	wire lower_band = s_tx_band;

	always_comb begin
		next_state = state;
		next_settle_count = settle_count;
		case (state)
			rtfc_pkg::RTFC_ST_SETTLE: begin
				// Wait until both synchroniser stages hold real input values
				if (settle_count == rtfc_pkg::SETTLE_CYCLES) begin
					next_state = rtfc_pkg::RTFC_ST_RUN;
				end else begin
					next_settle_count = settle_count + 2'h1;
				end
			end
			rtfc_pkg::RTFC_ST_RUN: begin
				next_state = rtfc_pkg::RTFC_ST_RUN;
			end
			default: begin
				next_state = rtfc_pkg::RTFC_ST_SETTLE;
				next_settle_count = 2'h0;
			end
		endcase
	end

	always_comb begin
		next_tx_ctrl.relay_tx = keyed;
		next_tx_ctrl.upper_pa_on = tx_permit & ~lower_band;
		next_tx_ctrl.lower_pa_on = tx_permit & lower_band;
		next_audio_ctrl.rx_to_amps = ~keyed;
		next_audio_ctrl.speaker_on = ~keyed;
		next_audio_ctrl.headphone_rx = ~keyed;
		next_audio_ctrl.headphone_sidetone = keyed;
		next_audio_ctrl.line_rx = ~keyed & ~fault;
		next_audio_ctrl.line_sidetone = keyed & ~fault;
		next_audio_ctrl.remote_audio_src = s_remote_sel;
		// Frequency mode falls back to amplitude routing in the lower band
		next_audio_ctrl.am_driver_route = s_am_sel | lower_band;
		next_audio_ctrl.depth_lower_band = lower_band;
		next_lamps.fault_lamp = fault & run;
		next_lamps.am_lamp = s_am_sel & run;
		next_lamps.fm_lamp = ~s_am_sel & ~lower_band & run;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= rtfc_pkg::RTFC_ST_SETTLE;
			settle_count <= 2'h0;
		end else begin
			state <= next_state;
			settle_count <= next_settle_count;
		end
	end

	// Registered outputs cost one cycle but keep glitches off the relay and lamps
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tx_ctrl <= '0;
			audio_ctrl <= '0;
			lamps <= '0;
			inputs_valid <= 1'b0;
		end else begin
			tx_ctrl <= next_tx_ctrl;
			audio_ctrl <= next_audio_ctrl;
			lamps <= next_lamps;
			inputs_valid <= run;
		end
	end

endmodule

// >>> sim/rtfc_far_side.sv
// Far-side model: synthesisers, amplifiers and panel switches as level pins
// Assumes the bench sets the scene off the clock edge
`timescale 1ns/1ps
module rtfc_far_side (
	input wire logic [10:0] scene,
	output logic [10:0] pins
);
	// Band flags high for lower band second oscillator lock level forwarded
	assign pins = scene;
endmodule

// >>> sim/rtfc_checker.sv
// Checks on keying, fault and lamp outputs
// Assumes three edges from input to output
`timescale 1ns/1ps
module rtfc_checker (
	input logic clk,
	input logic reset,
	input logic rx_osc1_unlock,
	input logic second_osc_unlock_n,
	input logic rx_osc3_unlock_n,
	input logic tx_unlock,
	input logic rx_band_flag,
	input logic tx_band_flag,
	input logic tx_power_ok,
	input logic local_key,
	input logic remote_key,
	input logic remote_select,
	input logic am_select,
	input rtfc_pkg::rtfc_tx_ctrl_t tx_ctrl,
	input rtfc_pkg::rtfc_audio_ctrl_t audio_ctrl,
	input rtfc_pkg::rtfc_lamps_t lamps,
	input logic inputs_valid
);
	wire key = remote_select ? remote_key : local_key;
	wire ok = key && !tx_unlock;
	wire fault = rx_osc1_unlock || !second_osc_unlock_n || !rx_osc3_unlock_n || tx_unlock
		|| rx_band_flag != tx_band_flag || key && !tx_power_ok;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Pipeline holds only post-reset samples
	sequence s_ok;
		inputs_valid && $past(inputs_valid, 3);
	endsequence
	chk_relay_keyed: assert property (s_ok |-> tx_ctrl.relay_tx == $past(key, 3))
		else $error("relay wrong");
	chk_pa_permit: assert property (tx_ctrl[2:1] != 2'h0 |-> $past(ok, 3))
		else $error("amplifier without permit");
	chk_band_pick: assert property (s_ok ##0 $past(ok, 3) |->
		tx_ctrl[2:1] == ($past(tx_band_flag, 3) ? 2'h1 : 2'h2)) else $error("band pick");
	chk_fault_lamp: assert property (s_ok |-> lamps.fault_lamp == $past(fault, 3))
		else $error("fault lamp wrong");
	chk_line_gate: assert property (lamps.fault_lamp |-> audio_ctrl[4:3] == 2'h0)
		else $error("line not blocked");
	chk_speaker_cut: assert property (s_ok |-> {audio_ctrl.speaker_on,
		audio_ctrl.headphone_sidetone} == {!$past(key, 3), $past(key, 3)}) else $error("spk");
	chk_mode_lamps: assert property (s_ok |-> {lamps.am_lamp, lamps.fm_lamp} ==
		$past({am_select, !am_select && !tx_band_flag}, 3)) else $error("mode lamps");
	chk_route_depth: assert property (s_ok |-> audio_ctrl[1:0] ==
		$past({am_select || tx_band_flag, tx_band_flag}, 3)) else $error("route");
	chk_rx_paths: assert property (s_ok |-> {audio_ctrl.rx_to_amps,
		audio_ctrl.headphone_rx} == {2{!$past(key, 3)}}) else $error("receive paths");
	chk_line_open: assert property (s_ok ##0 !lamps[2] |-> audio_ctrl[4:3] ==
		{!$past(key, 3), $past(key, 3)}) else $error("line path");
	chk_settle_quiet: assert property (!inputs_valid |-> tx_ctrl == 3'h0)
		else $error("keyed before settled");
endmodule
bind rtfc_top rtfc_checker rtfc_checker_i (.*);

// >>> sim/rtfc_top_bench.sv
// Table-driven bench for the fault and keying control
// Assumes the far-side model forwards pin levels
`timescale 1ns/1ps
module rtfc_top_bench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [10:0] scene = 11'h0c6;
	logic [10:0] p;
	rtfc_pkg::rtfc_tx_ctrl_t tx_ctrl;
	rtfc_pkg::rtfc_audio_ctrl_t audio_ctrl;
	rtfc_pkg::rtfc_lamps_t lamps;
	logic inputs_valid;
	int bad_count = 0;
	int n_tests = 0;
	logic [24:0] tbl [14] = '{{11'h046, 14'h01d0},
		{11'h0c6, 14'h2928}, {11'h146, 14'h01d0},
		{11'h346, 14'h292c}, {11'h2c6, 14'h01d4},
		{11'h0f6, 14'h182b}, {11'h0ce, 14'h0d20},
		{11'h086, 14'h2d20}, {11'h006, 14'h01d0},
		{11'h047, 14'h05c0}, {11'h044, 14'h05c0}, {11'h042, 14'h05c0},
		{11'h056, 14'h05c0}, {11'h446, 14'h02d2}};
	always #5 clk = ~clk;
	rtfc_far_side rtfc_far_side_i (.scene(scene), .pins(p));
	rtfc_top rtfc_top_i (.clk(clk), .reset(reset), .rx_osc1_unlock(p[0]),
		.second_osc_unlock_n(p[1]), .rx_osc3_unlock_n(p[2]), .tx_unlock(p[3]),
		.rx_band_flag(p[4]), .tx_band_flag(p[5]), .tx_power_ok(p[6]), .local_key(p[7]),
		.remote_key(p[8]), .remote_select(p[9]), .am_select(p[10]), .tx_ctrl(tx_ctrl),
		.audio_ctrl(audio_ctrl), .lamps(lamps), .inputs_valid(inputs_valid));
	task check(input logic [13:0] seen, input logic [13:0] want);
		n_tests++;
		if (seen !== want) begin
			bad_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, want);
		end
	endtask
	task final_report;
		$display("compares %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Whole table needs under 1 us
	initial begin
		#5000;
		bad_count++;
		final_report;
	end
	initial begin
		repeat (20) @(negedge clk);
		reset = 1'b0;
		repeat (2) @(negedge clk);
		check({10'h000, inputs_valid, tx_ctrl}, 14'h0000);
		for (int i = 0; i < 14; i++) begin
			scene = tbl[i][24:14];
			repeat (3) @(posedge clk);
			@(negedge clk);
			check({tx_ctrl, lamps, audio_ctrl[8:7], audio_ctrl[5:0]}, tbl[i][13:0]);
			check({12'h000, audio_ctrl[6], inputs_valid}, {12'h000, tbl[i][7], 1'b1});
			$display("test %0d done", i);
		end
		// Reset again with the key held: nothing may key until settled
		scene = 11'h0c6;
		reset = 1'b1;
		@(negedge clk);
		check({tx_ctrl, lamps, audio_ctrl[8:7], audio_ctrl[5:0]}, 14'h0000);
		reset = 1'b0;
		repeat (2) @(negedge clk);
		check({10'h000, inputs_valid, tx_ctrl}, 14'h0000);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check({tx_ctrl, lamps, audio_ctrl[8:7], audio_ctrl[5:0]}, 14'h2928);
		$display("test reset done");
		final_report;
	end
endmodule
